// ==== logic/sgd_consts.svh ====
// Purpose: offsets, field positions and reset values of the glass driver
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes: included by the design, the monitor and the bench
`ifndef SGD_CONSTS_SVH
`define SGD_CONSTS_SVH

// register byte addresses
`define SGD_ADR_COMMAND 32'h4003c000
`define SGD_ADR_CONFIG 32'h4003c004
`define SGD_ADR_FRAMEDIV 32'h4003c008
`define SGD_ADR_PRESENT 32'h4003c00c
`define SGD_ADR_STATUS 32'h4003c010
`define SGD_ADR_SEGMAP0 32'h4003c030
`define SGD_ADR_SEGMAP1 32'h4003c034

// command bits
`define SGD_CMD_TURN_ON 0
`define SGD_CMD_TURN_OFF 1
`define SGD_CMD_REINIT 3

// configuration register fields
`define SGD_CFG_COMMON_COUNT_SELECT_LSB 0
`define SGD_CFG_SEGMENT_COUNT_SELECT_LSB 8
`define SGD_CFG_BUFFER_ON_TIME_LSB 16
`define SGD_CFG_BIAS_LSB 20
`define SGD_CFG_LOWPWR_BIT 24

// frame divider fields
`define SGD_FRM_SLOW_CLOCK_PRESCALER_LSB 0
`define SGD_FRM_DIV_LSB 8

// presentation fields
`define SGD_PRS_MODE_LSB 0
`define SGD_PRS_BLINK_LSB 8

// limits and reset values
`define SGD_COM_MAX 3'h4
`define SGD_SEG_COUNT 50
`define SGD_SLOW_CLOCK_PRESCALER_BASE 11'h008
`define SGD_BUF_HALF 4'h8
`define SGD_BUF_FULL 4'h9
`define SGD_RESET_WORD 32'h00000000

`endif

// ==== logic/sgd_frame_control.sv ====
// Purpose: registers, frame divider and on/off sequencing of the driver
// Assumes: clock is the slow clock; classic Wishbone slave, one word each
// Notes: one cycle to ack; writes take effect on the ack edge
// Functional notes
// - turn-on bit enables; zero bits do nothing
// - turn-off takes effect at next frame start
// - reinit acts as reset, grounds all lines
// - common count 0..4 selects driven commons
// - no map: segments above count released
// - map active: segment driven when bit set
// - bias field picks static, half, third
// - low-power bit selects low-power waveform
// - buffer on-time sets nominal drive time
// - waveform and timing fields apply per frame; bias applies at once
// - prescaler divides by eight times power
// - divider divides prescaler output by n+1
// - presentation modes 0..7, memory untouched
// - blink rate frame rate over divisor
// - after turn-off one ground frame, then stop
// - reinit raises no disable-complete event
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "sgd_consts.svh"

module sgd_frame_control (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output sgd_pkg::sgd_pads_t pads,
	output sgd_pkg::sgd_frame_t frame
);
	import sgd_pkg::*;

	// all state lives in one register; st_nxt is its next value
	sgd_regs_t st_r;
	sgd_regs_t st_nxt;

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] mergeSel(input logic [31:0] oldW,
		input logic [31:0] newW, input logic [3:0] sel);
		logic [31:0] res;
		res = oldW;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = newW[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// last count of the prescaler: 8 << field, minus one
	function automatic logic [9:0] prescLast(input logic [2:0] p);
		logic [10:0] full;
		full = `SGD_SLOW_CLOCK_PRESCALER_BASE << p;
		return 10'(full - 11'h001);
	endfunction

	// buffer drive length in clock periods
	function automatic logic [7:0] bufLen(input logic [3:0] v);
		logic [7:0] len;
		len = 8'h00;
		if (v >= 4'h1 && v <= 4'h7) begin
			len = 8'h01 << v;
		end else if (v == `SGD_BUF_HALF || v == `SGD_BUF_FULL) begin
			len = 8'h01;
		end
		return len;
	endfunction

	// word views of the stored registers
	function automatic logic [31:0] cfgWord(input sgd_regs_t s);
		logic [31:0] w;
		w = `SGD_RESET_WORD;
		w[`SGD_CFG_COMMON_COUNT_SELECT_LSB +: 3] = s.common_count_select;
		w[`SGD_CFG_SEGMENT_COUNT_SELECT_LSB +: 6] = s.segment_count_select;
		w[`SGD_CFG_BUFFER_ON_TIME_LSB +: 4] = s.pend.bufOnTime;
		w[`SGD_CFG_BIAS_LSB +: 2] = s.bias;
		w[`SGD_CFG_LOWPWR_BIT] = s.pend.lowPower;
		return w;
	endfunction

	function automatic logic [31:0] frmWord(input sgd_regs_t s);
		logic [31:0] w;
		w = `SGD_RESET_WORD;
		w[`SGD_FRM_SLOW_CLOCK_PRESCALER_LSB +: 3] = s.pend.prescaler;
		w[`SGD_FRM_DIV_LSB +: 3] = s.pend.divider;
		return w;
	endfunction

	function automatic logic [31:0] prsWord(input sgd_regs_t s);
		logic [31:0] w;
		w = `SGD_RESET_WORD;
		w[`SGD_PRS_MODE_LSB +: 3] = s.pend.display_presentation_mode;
		w[`SGD_PRS_BLINK_LSB +: 8] = s.pend.blinkDiv;
		return w;
	endfunction

	// decoded bus and frame timing nets
	logic reqOn;
	logic wrTake;
	logic [31:0] wrCfg;
	logic [31:0] wrFrm;
	logic [31:0] wrPrs;
	logic [31:0] wrMap0;
	logic [31:0] wrMap1;
	logic running;
	logic tick;
	logic step;
	logic frameDone;
	logic [2:0] comLimit;

	// bus qualifiers and merged write words
	assign reqOn = cyc_i && stb_i;
	assign wrTake = reqOn && we_i && st_r.ack;
	assign wrCfg = mergeSel(cfgWord(st_r), dat_i, sel_i);
	assign wrFrm = mergeSel(frmWord(st_r), dat_i, sel_i);
	assign wrPrs = mergeSel(prsWord(st_r), dat_i, sel_i);
	assign wrMap0 = mergeSel(st_r.segMap[31:0], dat_i, sel_i);
	assign wrMap1 = mergeSel({14'h0000, st_r.segMap[49:32]}, dat_i, sel_i);

	// frame sequencing ticks from the divided slow clock
	assign comLimit = (st_r.common_count_select > `SGD_COM_MAX) ? `SGD_COM_MAX
		: st_r.common_count_select;
	assign running = st_r.state != SGD_IDLE;
	assign tick = running && st_r.prescCnt == prescLast(st_r.act.prescaler);
	assign step = tick && st_r.divCnt == st_r.act.divider;
	assign frameDone = step && st_r.comIdx == comLimit;

	// next state of every register
	always_comb begin
		st_nxt = st_r;
		// event pulses last one cycle; ack answers a cycle after a request
		st_nxt.frameEnd = 1'b0;
		st_nxt.disDone = 1'b0;
		st_nxt.ack = reqOn && !st_r.ack;

		// frame counters
		if (running) begin
			st_nxt.prescCnt = tick ? 10'h000 : st_r.prescCnt + 10'h001;
			if (tick) begin
				st_nxt.divCnt = step ? 3'h0 : st_r.divCnt + 3'h1;
			end
			if (step) begin
				st_nxt.comIdx = frameDone ? 3'h0 : st_r.comIdx + 3'h1;
				st_nxt.bufCnt = bufLen(st_r.act.bufOnTime);
			end else if (st_r.bufCnt != 8'h00) begin
				st_nxt.bufCnt = st_r.bufCnt - 8'h01;
			end
		end

		// frame boundary: blink, apply pending fields, turn-off sequence
		if (frameDone) begin
			st_nxt.frameEnd = 1'b1;
			st_nxt.act = st_r.pend;
			// first common of the new frame already gets the new drive time
			st_nxt.bufCnt = bufLen(st_r.pend.bufOnTime);
			// blink phase flips every divisor frames; zero parks it low
			if (st_r.act.blinkDiv == 8'h00) begin
				st_nxt.blinkCnt = 8'h00;
				st_nxt.blinkPhase = 1'b0;
			end else if (st_r.blinkCnt >= st_r.act.blinkDiv - 8'h01) begin
				st_nxt.blinkCnt = 8'h00;
				st_nxt.blinkPhase = !st_r.blinkPhase;
			end else begin
				st_nxt.blinkCnt = st_r.blinkCnt + 8'h01;
			end
			// turn-off sequence: one ground frame, then idle
			unique case (st_r.state)
				SGD_RUN: begin
					if (st_r.disPend) begin
						st_nxt.state = SGD_GROUND;
						st_nxt.disPend = 1'b0;
					end
				end
				SGD_GROUND: begin
					st_nxt.state = SGD_IDLE;
					st_nxt.disDone = 1'b1;
					st_nxt.disPend = 1'b0; // no stale request after stop
					st_nxt.prescCnt = 10'h000;
					st_nxt.divCnt = 3'h0;
					st_nxt.bufCnt = 8'h00;
				end
				SGD_IDLE: begin
				end
			endcase
		end

		// register reads, prepared for the ack cycle
		if (reqOn && !st_r.ack) begin
			unique case (adr_i)
				`SGD_ADR_CONFIG: st_nxt.rdata = cfgWord(st_r);
				`SGD_ADR_FRAMEDIV: st_nxt.rdata = frmWord(st_r);
				`SGD_ADR_PRESENT: st_nxt.rdata = prsWord(st_r);
				`SGD_ADR_STATUS: st_nxt.rdata = {31'h00000000, running};
				`SGD_ADR_SEGMAP0: st_nxt.rdata = st_r.segMap[31:0];
				`SGD_ADR_SEGMAP1: st_nxt.rdata = {14'h0000, st_r.segMap[49:32]};
				default: st_nxt.rdata = `SGD_RESET_WORD;
			endcase
		end

		// register writes on the ack edge; reserved bits dropped
		if (wrTake) begin
			unique case (adr_i)
				`SGD_ADR_CONFIG: begin
					st_nxt.common_count_select = wrCfg[`SGD_CFG_COMMON_COUNT_SELECT_LSB +: 3];
					st_nxt.segment_count_select = wrCfg[`SGD_CFG_SEGMENT_COUNT_SELECT_LSB +: 6];
					st_nxt.pend.bufOnTime = wrCfg[`SGD_CFG_BUFFER_ON_TIME_LSB +: 4];
					st_nxt.bias = wrCfg[`SGD_CFG_BIAS_LSB +: 2];
					st_nxt.pend.lowPower = wrCfg[`SGD_CFG_LOWPWR_BIT];
				end
				`SGD_ADR_FRAMEDIV: begin
					st_nxt.pend.prescaler = wrFrm[`SGD_FRM_SLOW_CLOCK_PRESCALER_LSB +: 3];
					st_nxt.pend.divider = wrFrm[`SGD_FRM_DIV_LSB +: 3];
				end
				`SGD_ADR_PRESENT: begin
					st_nxt.pend.display_presentation_mode = wrPrs[`SGD_PRS_MODE_LSB +: 3];
					st_nxt.pend.blinkDiv = wrPrs[`SGD_PRS_BLINK_LSB +: 8];
				end
				`SGD_ADR_SEGMAP0: st_nxt.segMap[31:0] = wrMap0;
				`SGD_ADR_SEGMAP1: st_nxt.segMap[49:32] = wrMap1[17:0];
				`SGD_ADR_COMMAND: begin
					// turn-on from idle restarts the frame counters
					if (sel_i[0] && dat_i[`SGD_CMD_TURN_ON]
						&& st_r.state == SGD_IDLE) begin
						st_nxt.state = SGD_RUN;
						st_nxt.act = st_nxt.pend;
						st_nxt.prescCnt = 10'h000;
						st_nxt.divCnt = 3'h0;
						st_nxt.comIdx = 3'h0;
						st_nxt.bufCnt = bufLen(st_nxt.pend.bufOnTime);
					end
					// turn-off is only marked; a turn-on in the same word counts
					if (sel_i[0] && dat_i[`SGD_CMD_TURN_OFF]
						&& st_nxt.state != SGD_IDLE) begin
						st_nxt.disPend = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// reinit wins over everything and raises no completion
		if (wrTake && adr_i == `SGD_ADR_COMMAND && sel_i[0]
			&& dat_i[`SGD_CMD_REINIT]) begin
			st_nxt = SGD_REGS_RESET;
		end
	end

	// the single state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= SGD_REGS_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// pin ownership: commons and segments handed to the driver
	always_comb begin
		pads.allGround = st_r.state != SGD_RUN;
		// reserved common counts above four act as four
		for (int c = 0; c < 5; c++) begin
			pads.comDrive[c] = running && 3'(c) <= comLimit;
		end
		for (int n = 0; n < `SGD_SEG_COUNT; n++) begin
			if (st_r.segMap != 50'h0) begin
				pads.segDrive[n] = running && st_r.segMap[n];
			end else begin
				pads.segDrive[n] = running && 6'(n) <= st_r.segment_count_select;
			end
		end
	end

	// frame timing and waveform selection
	always_comb begin
		// applied copies only; bias is raw and follows any config write at once
		frame.enabled = running;
		frame.comIdx = st_r.comIdx;
		frame.frameEnd = st_r.frameEnd;
		frame.disDone = st_r.disDone;
		frame.bias = st_r.bias;
		frame.lowPower = st_r.act.lowPower;
		frame.bufOnTime = st_r.act.bufOnTime;
		frame.bufDrive = st_r.bufCnt != 8'h00;
		frame.bufHalf = st_r.act.bufOnTime == `SGD_BUF_HALF;
		frame.display_presentation_mode = st_r.act.display_presentation_mode;
		frame.blinkPhase = st_r.blinkPhase;
	end

	// bus answers
	assign ack_o = st_r.ack;
	assign dat_o = st_r.rdata;

endmodule

// ==== logic/sgd_pkg.sv ====
// Purpose: types shared by the glass driver frame control
// Assumes: constants come from sgd_consts.svh
// Notes: all state of the module is one sgd_regs_t
package sgd_pkg;

	typedef enum logic [2:0] {
		SGD_IDLE = 3'b001,
		SGD_RUN = 3'b010,
		SGD_GROUND = 3'b100
	} sgd_state_t;

	// fields applied only at a frame boundary or at turn-on from idle
	typedef struct packed {
		logic lowPower;
		logic [3:0] bufOnTime;
		logic [2:0] prescaler;
		logic [2:0] divider;
		logic [2:0] display_presentation_mode;
		logic [7:0] blinkDiv;
	} sgd_frame_cfg_t;

	typedef struct packed {
		sgd_state_t state;
		logic [2:0] common_count_select;
		logic [5:0] segment_count_select;
		logic [1:0] bias;
		sgd_frame_cfg_t pend;
		sgd_frame_cfg_t act;
		logic [49:0] segMap;
		logic disPend;
		logic [9:0] prescCnt;
		logic [2:0] divCnt;
		logic [2:0] comIdx;
		logic [7:0] blinkCnt;
		logic blinkPhase;
		logic [7:0] bufCnt;
		logic frameEnd;
		logic disDone;
		logic ack;
		logic [31:0] rdata;
	} sgd_regs_t;

	localparam sgd_regs_t SGD_REGS_RESET = '{state: SGD_IDLE, default: '0};

	// pin ownership towards the pad multiplexers
	typedef struct packed {
		logic [4:0] comDrive;
		logic [49:0] segDrive;
		logic allGround;
	} sgd_pads_t;

	// frame timing and waveform selection towards the waveform generator
	typedef struct packed {
		logic enabled;
		logic [2:0] comIdx;
		logic frameEnd;
		logic disDone;
		logic [1:0] bias;
		logic lowPower;
		logic [3:0] bufOnTime;
		logic bufDrive;
		logic bufHalf;
		logic [2:0] display_presentation_mode;
		logic blinkPhase;
	} sgd_frame_t;

endpackage

// ==== test/sgd_frame_control_bench.sv ====
// Purpose: self-checking bench of sgd_frame_control
// Assumes: 100 MHz clock, reset held 20 cycles
// Notes: glass model measures frame length
`timescale 1ns/100ps
`include "sgd_consts.svh"
module sgd_frame_control_bench;
	import sgd_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic [3:0] lanes = 4'hf;
	logic [31:0] rdat;
	logic [31:0] got;
	logic ack;
	sgd_pads_t pads;
	sgd_frame_t frame;
	int frameLen;
	int errors = 0;
	int nCompared = 0;
	int cycles = 0;
	// clock
	always #5 clock = ~clock;
	sgd_frame_control uut (.clock(clock), .sys_rst(sys_rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .pads(pads), .frame(frame));
	sgd_glass_model glass (.clock(clock), .pads(pads), .frame(frame),
		.frameLen(frameLen));
	// verdict and end of run
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [63:0] g, input logic [63:0] e,
		input string what);
		nCompared++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %s %h not %h", $time, what, g, e);
		end
	endtask
	// one classic cycle, held until ack
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= lanes;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1);
		check(n, 2, "ack latency");
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(got, e, "read");
	endtask
	// wait for frame end or disable event
	task automatic wait_ev(input bit done);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while ((done ? frame.disDone : frame.frameEnd) !== 1'b1
			&& n < 5000);
		check(n < 5000, 1'b1, "event");
		@(posedge clock);
	endtask
	task automatic t_regs();
		rd(`SGD_ADR_CONFIG, 32'h0);
		rd(`SGD_ADR_FRAMEDIV, 32'h0);
		rd(`SGD_ADR_COMMAND, 32'h0);
		rd(32'h4003c0f0, 32'h0);
		bus(1'b1, `SGD_ADR_CONFIG, 32'hffffffff);
		rd(`SGD_ADR_CONFIG, 32'h013f3f07);
		bus(1'b1, `SGD_ADR_FRAMEDIV, 32'hffffffff);
		rd(`SGD_ADR_FRAMEDIV, 32'h00000707);
		bus(1'b1, `SGD_ADR_FRAMEDIV, 32'h0);
		lanes = 4'h1;
		bus(1'b1, `SGD_ADR_PRESENT, 32'hffffffff);
		lanes = 4'hf;
		rd(`SGD_ADR_PRESENT, 32'h00000007);
		for (int b = 0; b < 3; b++) begin
			bus(1'b1, `SGD_ADR_CONFIG, b << 20);
			@(posedge clock);
			check(frame.bias, b, "bias");
		end
		$display("regs test done");
	endtask
	task automatic t_run();
		bus(1'b1, `SGD_ADR_CONFIG, 32'h00000402);
		bus(1'b1, `SGD_ADR_COMMAND, 32'h0);
		@(posedge clock);
		check(frame.enabled, 1'b0, "zero command");
		bus(1'b1, `SGD_ADR_COMMAND, 32'h1);
		@(posedge clock);
		check(frame.enabled, 1'b1, "enabled");
		check(pads.comDrive, 5'h07, "commons");
		check(pads.segDrive, 50'h1f, "segments");
		rd(`SGD_ADR_STATUS, 32'h1);
		bus(1'b1, `SGD_ADR_SEGMAP0, 32'h5);
		@(posedge clock);
		check(pads.segDrive, 50'h5, "remap");
		bus(1'b1, `SGD_ADR_SEGMAP1, 32'hffffffff);
		rd(`SGD_ADR_SEGMAP1, 32'h0003ffff);
		@(posedge clock);
		check(pads.segDrive, 50'h3ffff00000005, "upper remap");
		bus(1'b1, `SGD_ADR_SEGMAP1, 32'h0);
		bus(1'b1, `SGD_ADR_SEGMAP0, 32'h0);
		@(posedge clock);
		check(pads.segDrive, 50'h1f, "unmapped again");
		$display("run test done");
	endtask
	task automatic t_rates();
		for (int p = 0; p < 16; p++) begin
			bus(1'b1, `SGD_ADR_FRAMEDIV, p < 8 ? p : (p - 8) << 8);
			wait_ev(1'b0);
			wait_ev(1'b0);
			check(frameLen, p < 8 ? 24 << p : 24 * (p - 7), "len");
		end
		$display("rate test done");
	endtask
	task automatic t_modes();
		for (int i = 0; i < 10; i++) begin
			wait_ev(1'b0);
			bus(1'b1, `SGD_ADR_PRESENT, i % 8);
			bus(1'b1, `SGD_ADR_CONFIG, 32'h402 | (i << 16) | ((i % 2) << 24));
			@(posedge clock);
			if (i > 0) check(frame.display_presentation_mode, (i - 1) % 8, "held");
			wait_ev(1'b0);
			check(frame.display_presentation_mode, i % 8, "mode");
			check(frame.bufOnTime, i, "on time");
			check(frame.lowPower, i % 2, "low power");
			check(frame.bufHalf, i == 8, "half drive");
			check(frame.blinkPhase, 1'b0, "no blink");
		end
		bus(1'b1, `SGD_ADR_PRESENT, 32'h00000203);
		wait_ev(1'b0);
		check(frame.display_presentation_mode, 3'h3, "blinking");
		for (int f = 0; f < 6; f++) begin
			check(frame.blinkPhase, f[1], "blink");
			wait_ev(1'b0);
		end
		bus(1'b1, `SGD_ADR_PRESENT, 32'h00000003);
		wait_ev(1'b0);
		wait_ev(1'b0);
		check(frame.blinkPhase, 1'b0, "blink stopped");
		$display("mode test done");
	endtask
	task automatic t_off();
		bus(1'b1, `SGD_ADR_COMMAND, 32'h2);
		@(posedge clock);
		check(pads.allGround, 1'b0, "still running");
		wait_ev(1'b0);
		check(pads.allGround, 1'b1, "ground frame");
		check(pads.comDrive, 5'h07, "still owned");
		wait_ev(1'b1);
		check(frame.enabled, 1'b0, "stopped");
		rd(`SGD_ADR_STATUS, 32'h0);
		bus(1'b1, `SGD_ADR_COMMAND, 32'h1);
		bus(1'b1, `SGD_ADR_COMMAND, 32'h8);
		@(posedge clock);
		check(pads.allGround, 1'b1, "reinit ground");
		check(frame.enabled, 1'b0, "reinit off");
		rd(`SGD_ADR_CONFIG, 32'h0);
		$display("off test done");
	endtask
	// main sequence
	initial begin
		sys_rst <= 1'b1; // an edge the async reset can see
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs();
		t_run();
		t_rates();
		t_modes();
		t_off();
		finish_test();
	end
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles >= 40000) begin
			errors++;
			$display("wrong value at %0t: run timed out", $time);
			finish_test();
		end
	end
endmodule
bind sgd_frame_control sgd_frame_control_monitor mon (.clock(clock),
	.sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .pads(pads), .frame(frame));

// ==== test/sgd_frame_control_monitor.sv ====
// Purpose: port checker of sgd_frame_control
// Assumes: bound from the bench, one clock domain
// Notes: watches the bus inputs and what the design drives
`timescale 1ns/100ps
`include "sgd_consts.svh"
module sgd_frame_control_monitor (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire sgd_pkg::sgd_pads_t pads,
	input wire sgd_pkg::sgd_frame_t frame
);
	import sgd_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic cmdWr;
	// command write landing on this edge
	assign cmdWr = ack_o && cyc_i && stb_i && we_i && sel_i[0]
		&& adr_i == `SGD_ADR_COMMAND;
	// command steps
	sequence s_reinit;
		cmdWr && dat_i[3];
	endsequence
	sequence s_turn_on;
		cmdWr && dat_i[0] && !dat_i[3] && !frame.enabled
			&& pads.comDrive == 5'h00;
	endsequence
	sequence s_turn_off;
		cmdWr && dat_i[1] && !dat_i[3] && frame.enabled && !pads.allGround;
	endsequence
	a_turn_on_enables: assert property (s_turn_on |=> frame.enabled)
		else $error("turn-on did not enable");
	a_off_deferred: assert property (s_turn_off |=> !pads.allGround)
		else $error("turn-off acted at once");
	a_reinit_ground: assert property (s_reinit |=> pads.allGround
		&& pads.comDrive == 5'h00 && pads.segDrive == '0 && !frame.enabled)
		else $error("reinit did not ground lines");
	a_reinit_quiet: assert property (s_reinit |=> !frame.disDone [*2])
		else $error("reinit raised disable event");
	a_common_index: assert property (frame.comIdx <= 3'h4)
		else $error("common index beyond four");
	a_frame_spacing: assert property ($rose(frame.frameEnd)
		|=> !frame.frameEnd [*7])
		else $error("frames closer than eight cycles");
	a_applied_hold: assert property ($changed({frame.lowPower,
		frame.bufOnTime, frame.display_presentation_mode})
		|-> frame.frameEnd || $past(frame.frameEnd) || $past(ack_o))
		else $error("applied field changed mid frame");
	// a common step under a one-cycle or a zero buffer drive time
	sequence s_step_short;
		$changed(frame.comIdx) && frame.enabled
			&& (frame.bufOnTime == `SGD_BUF_HALF
			|| frame.bufOnTime == `SGD_BUF_FULL);
	endsequence
	sequence s_step_none;
		$changed(frame.comIdx) && frame.enabled && frame.bufOnTime == 4'h0;
	endsequence
	a_buf_half: assert property (s_step_short
		|-> frame.bufDrive ##1 !frame.bufDrive)
		else $error("one-cycle buffer drive wrong");
	a_buf_none: assert property (s_step_none |-> !frame.bufDrive)
		else $error("buffer drive while off");
	a_done_stops: assert property (frame.disDone
		|-> ##[0:1] (pads.comDrive == 5'h00 && !frame.enabled))
		else $error("driver still on after disable event");
endmodule

// ==== test/sgd_glass_model.sv ====
// Purpose: glass on the common and segment pins
// Assumes: frame end flag is a one-cycle pulse
// Notes: passive load, measures frame length
`timescale 1ns/100ps
module sgd_glass_model (
	input wire logic clock,
	input wire sgd_pkg::sgd_pads_t pads,
	input wire sgd_pkg::sgd_frame_t frame,
	output int frameLen
);
	import sgd_pkg::*;
	int run = 0;
	// cycles between two frame ends
	always @(posedge clock) begin
		run = run + 1;
		if (frame.frameEnd === 1'b1) begin
			frameLen = run;
			run = 0;
		end
	end
endmodule
